// file: lws_pkg.sv
// Purpose: Shared constants and types for the write-burst sequencing link
// Assumes: Single 125 MHz clock; strobes sampled as synchronous levels
// Notes: Timing counts are derived from times in nanoseconds
package lws_pkg;
	// Command encodings on the link
	typedef enum logic [2:0] {
		LWS_CMD_NOP,
		LWS_CMD_READ,
		LWS_CMD_WRITE,
		LWS_CMD_PRECHARGE,
		LWS_CMD_BURST_STOP,
		LWS_CMD_ACTIVE
	} lws_cmd_e;
	// Clock period
	localparam int CLK_PERIOD_NS = 8;
	// Organisation: four byte lanes, 32-bit data
	localparam int LANES = 4;
	localparam int DATA_W = 32;
	localparam int BANK_W = 2;
	localparam int COL_W = 9;
	localparam int ROW_W = 13;
	localparam int BANKS = 4;
	// Burst length (elements)
	localparam logic [4:0] BURST_LENGTH = 5'h04;
	// Times in nanoseconds
	localparam int WRITE_RECOVERY_TIME_NS = 15;
	localparam int WRITE_TO_READ_DELAY_NS = 16;
	localparam int ROW_PRECHARGE_TIME_NS = 18;
	localparam int ROW_ACTIVE_MIN_TIME_NS = 42;
	// Least times round up to whole cycles
	localparam int WR_CYC = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WTR_CYC = (WRITE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RP_CYC = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAS_CYC = (ROW_ACTIVE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Counter width for timers
	localparam int TMR_W = 5;
	// Write data FIFO depth
	localparam int FIFO_DEPTH = 32;
endpackage : lws_pkg

// file: lws_if.sv
// Purpose: Link between memory controller end and memory device end
// Assumes: Both ends clocked by the same system clock
// Notes: Data and strobes are three-signal pins; wire level resolved here
interface lws_if;
	logic [2:0] cmd; // Command
	logic [lws_pkg::BANK_W-1:0] bank; // Bank address
	logic [lws_pkg::COL_W-1:0] col; // Column address
	logic [lws_pkg::ROW_W-1:0] row; // Row address for activate
	logic auto_pre; // Auto precharge choice
	logic [lws_pkg::DATA_W-1:0] dq_c; // Data driven by controller
	logic [lws_pkg::DATA_W-1:0] dq_d; // Data driven by device
	logic dq_c_oe_n; // Controller drives data, low active
	logic dq_d_oe_n; // Device drives data, low active
	logic [lws_pkg::LANES-1:0] strobe_c; // Strobe from controller
	logic [lws_pkg::LANES-1:0] strobe_d; // Strobe from device
	logic strobe_c_oe_n; // Controller drives strobes, low active
	logic strobe_d_oe_n; // Device drives strobes, low active
	logic [lws_pkg::LANES-1:0] byte_write_mask; // Mask per lane
	logic [lws_pkg::DATA_W-1:0] dq; // Resolved data wire
	logic [lws_pkg::LANES-1:0] strobe; // Resolved strobe wire
	// Wire resolution; an undriven bus reads as zero
	assign dq = !dq_c_oe_n ? dq_c : (!dq_d_oe_n ? dq_d : '0);
	assign strobe = !strobe_c_oe_n ? strobe_c : (!strobe_d_oe_n ? strobe_d : '0);
	modport ctrl (output cmd, bank, col, row, auto_pre, dq_c, dq_c_oe_n, strobe_c,
		strobe_c_oe_n, byte_write_mask, input dq, strobe);
	modport mem (input cmd, bank, col, row, auto_pre, dq, strobe, byte_write_mask,
		output dq_d, dq_d_oe_n, strobe_d, strobe_d_oe_n);
endinterface : lws_if

// file: lws_fifo.sv
// Purpose: Valid/ready FIFO in flip-flops
// Assumes: One clock, asynchronous active-high reset
// Notes: Full and empty are exact; no bypass path
module lws_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH]; // Storage
	logic [AW-1:0] wp_r, wp_nxt; // Write index
	logic [AW-1:0] rp_r, rp_nxt; // Read index
	logic [AW:0] cnt_r, cnt_nxt; // Occupancy
	logic push, pop;
	// Handshakes
	always_comb begin
		push = in_valid_in && (cnt_r != (AW+1)'(DEPTH));
		pop = (cnt_r != '0) && out_ready_in;
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end
	// Pointer registers
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// Storage, no reset needed
	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem_r[wp_r] <= in_data_in;
		end
	end
	assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out = mem_r[rp_r];
endmodule : lws_fifo

// file: lws_mem_end.sv
// Purpose: Memory device end: write capture, masking, bank timing
// Assumes: Strobe levels sampled on clk_sys_in; array is a small model
// Notes: Function
module lws_mem_end (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// Link
	lws_if.mem link,
	// Status
	output logic [lws_pkg::BANKS-1:0] bank_open_out,
	output logic write_busy_out,
	output logic [lws_pkg::DATA_W-1:0] peek_data_out,
	input wire logic [3:0] peek_addr_in
);
	localparam int N = lws_pkg::LANES;
	logic [lws_pkg::DATA_W-1:0] array_r [16]; // Small array, low column bits
	logic [N-1:0] stb_prev_r; // Previous strobe sample
	logic [4:0] left_r, left_nxt; // Elements left to capture
	logic [3:0] col_r, col_nxt; // Current column
	logic armed_r, armed_nxt; // Awaiting first rising edge
	logic [1:0] wbank_r, wbank_nxt; // Bank of write
	logic wap_r, wap_nxt; // Write auto precharge pending
	logic [lws_pkg::TMR_W-1:0] wr_tmr_r, wr_tmr_nxt; // Recovery after last pair
	logic [lws_pkg::BANKS-1:0] open_r, open_nxt;
	logic [lws_pkg::TMR_W-1:0] rp_tmr_r [lws_pkg::BANKS];
	logic [lws_pkg::TMR_W-1:0] rp_tmr_nxt [lws_pkg::BANKS];
	logic [lws_pkg::TMR_W-1:0] ras_tmr_r [lws_pkg::BANKS];
	logic [lws_pkg::TMR_W-1:0] ras_tmr_nxt [lws_pkg::BANKS];
	logic [lws_pkg::TMR_W-1:0] rap_tmr_r, rap_tmr_nxt; // Read auto precharge timer
	logic [1:0] rbank_r, rbank_nxt;
	logic rap_r, rap_nxt;
	logic [N-1:0] edge_any; // Any strobe edge per lane
	logic [N-1:0] rise; // Rising edge per lane
	logic capture;
	logic [lws_pkg::DATA_W-1:0] wdata;
	logic bank_ok; // Target bank not precharging
	// Edge detect per lane; strobe n qualifies byte lane n
	always_comb begin
		rise = link.strobe & ~stb_prev_r;
		edge_any = link.strobe ^ stb_prev_r;
		bank_ok = (rp_tmr_r[link.bank] == '0);
		// First element on rising edge, later on any edge
		capture = (left_r != '0) && (armed_r ? rise[0] : edge_any[0]);
		wdata = array_r[col_r];
	end
	// Masked merge per byte lane
	wire logic [lws_pkg::DATA_W-1:0] merged_word; // Array word after lane merge
	genvar g;
	for (g = 0; g < N; g++) begin : g_lane
		logic lane_edge; // Own strobe moved this cycle
		// Lane g kept unless its own strobe moved and its mask is low
		assign lane_edge = armed_r ? rise[g] : edge_any[g];
		assign merged_word[8*g +: 8] = (link.byte_write_mask[g] || !lane_edge)
			? wdata[8*g +: 8] : link.dq[8*g +: 8];
	end
	// Command and burst sequencing
	always_comb begin
		left_nxt = left_r;
		col_nxt = col_r;
		armed_nxt = armed_r;
		wbank_nxt = wbank_r;
		wap_nxt = wap_r;
		wr_tmr_nxt = (wr_tmr_r != '0) ? wr_tmr_r - 1'b1 : wr_tmr_r;
		open_nxt = open_r;
		rap_nxt = rap_r;
		rbank_nxt = rbank_r;
		rap_tmr_nxt = (rap_tmr_r != '0) ? rap_tmr_r - 1'b1 : rap_tmr_r;
		for (int b = 0; b < lws_pkg::BANKS; b++) begin
			rp_tmr_nxt[b] = (rp_tmr_r[b] != '0) ? rp_tmr_r[b] - 1'b1 : rp_tmr_r[b];
			ras_tmr_nxt[b] = (ras_tmr_r[b] != '0) ? ras_tmr_r[b] - 1'b1 : ras_tmr_r[b];
		end
		// Element capture advances column
		if (capture) begin
			armed_nxt = 1'b0;
			left_nxt = left_r - 1'b1;
			col_nxt = col_r + 1'b1;
			if (left_r == 5'h01) begin
				// Last pair taken: recovery starts
				wr_tmr_nxt = lws_pkg::TMR_W'(lws_pkg::WR_CYC);
			end
		end
		// Write auto precharge once recovery expires
		if (wap_r && left_r == '0 && wr_tmr_r == 5'h01) begin
			wap_nxt = 1'b0;
			open_nxt[wbank_r] = 1'b0;
			rp_tmr_nxt[wbank_r] = lws_pkg::TMR_W'(lws_pkg::RP_CYC);
		end
		// Read auto precharge at BL/2, held off by minimum row active time
		if (rap_r && rap_tmr_r == '0 && ras_tmr_r[rbank_r] == '0) begin
			rap_nxt = 1'b0;
			open_nxt[rbank_r] = 1'b0;
			rp_tmr_nxt[rbank_r] = lws_pkg::TMR_W'(lws_pkg::RP_CYC);
		end
		if (bank_ok) begin
			case (link.cmd)
				lws_pkg::LWS_CMD_ACTIVE: begin
					open_nxt[link.bank] = 1'b1;
					ras_tmr_nxt[link.bank] = lws_pkg::TMR_W'(lws_pkg::RAS_CYC);
				end
				lws_pkg::LWS_CMD_WRITE: begin
					// New write concatenates or truncates prior burst
					left_nxt = lws_pkg::BURST_LENGTH;
					col_nxt = link.col[3:0];
					armed_nxt = (left_r == '0) || armed_r;
					wbank_nxt = link.bank;
					wap_nxt = link.auto_pre;
				end
				lws_pkg::LWS_CMD_READ: begin
					// Truncating read: later elements dropped
					left_nxt = '0;
					rbank_nxt = link.bank;
					rap_nxt = link.auto_pre;
					// Counted from the edge after the read, hence one less
					rap_tmr_nxt = lws_pkg::TMR_W'((lws_pkg::BURST_LENGTH >> 1) - 1);
				end
				lws_pkg::LWS_CMD_PRECHARGE: begin
					// Precharge cuts the access; only an open bank is closed and timed
					if (open_r[link.bank]) begin
						open_nxt[link.bank] = 1'b0;
						rp_tmr_nxt[link.bank] = lws_pkg::TMR_W'(lws_pkg::RP_CYC);
					end
					left_nxt = '0;
				end
				lws_pkg::LWS_CMD_BURST_STOP: begin
					// Read ends; row stays open
					rap_nxt = 1'b0;
				end
				default: begin
				end
			endcase
		end
	end
	// Sequencing registers
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			stb_prev_r <= '0;
			left_r <= '0;
			col_r <= '0;
			armed_r <= 1'b0;
			wbank_r <= '0;
			wap_r <= 1'b0;
			wr_tmr_r <= '0;
			open_r <= '0;
			rap_r <= 1'b0;
			rbank_r <= '0;
			rap_tmr_r <= '0;
			for (int b = 0; b < lws_pkg::BANKS; b++) begin
				rp_tmr_r[b] <= '0;
				ras_tmr_r[b] <= '0;
			end
		end else begin
			stb_prev_r <= link.strobe;
			left_r <= left_nxt;
			col_r <= col_nxt;
			armed_r <= armed_nxt;
			wbank_r <= wbank_nxt;
			wap_r <= wap_nxt;
			wr_tmr_r <= wr_tmr_nxt;
			open_r <= open_nxt;
			rap_r <= rap_nxt;
			rbank_r <= rbank_nxt;
			rap_tmr_r <= rap_tmr_nxt;
			for (int b = 0; b < lws_pkg::BANKS; b++) begin
				rp_tmr_r[b] <= rp_tmr_nxt[b];
				ras_tmr_r[b] <= ras_tmr_nxt[b];
			end
		end
	end
	// Array write: only captured elements, masked lanes kept
	always_ff @(posedge clk_sys_in) begin
		if (capture) begin
			array_r[col_r] <= merged_word;
		end
	end
	// Device never drives during writes; idle pins stay released
	assign link.dq_d = '0;
	assign link.dq_d_oe_n = 1'b1;
	assign link.strobe_d = '0;
	assign link.strobe_d_oe_n = 1'b1;
	// Status outputs from flip-flops
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			bank_open_out <= '0;
			write_busy_out <= 1'b0;
			peek_data_out <= '0;
		end else begin
			bank_open_out <= open_nxt;
			write_busy_out <= (left_nxt != '0) || (wr_tmr_nxt != '0);
			peek_data_out <= array_r[peek_addr_in];
		end
	end
endmodule : lws_mem_end

// file: lws_ctrl_end.sv
// Purpose: Controller end: issues writes, drives data, strobe and mask
// Assumes: Strobe toggles at clock rate as sampled levels
// Notes: Write data enters through a 32-word FIFO
module lws_ctrl_end (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// Link
	lws_if.ctrl link,
	// Write request
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic [lws_pkg::BANK_W-1:0] req_bank_in,
	input wire logic [lws_pkg::COL_W-1:0] req_col_in,
	input wire logic req_auto_pre_in,
	// Write data stream with lane mask
	input wire logic wd_valid_in,
	output logic wd_ready_out,
	input wire logic [lws_pkg::DATA_W+lws_pkg::LANES-1:0] wd_data_in,
	// Status
	output logic busy_out
);
	localparam int W = lws_pkg::DATA_W + lws_pkg::LANES;
	typedef enum {S_IDLE, S_PRE, S_DATA, S_POST, S_REC} lws_st_e;
	lws_st_e st_r, st_nxt;
	logic f_valid, f_ready;
	logic [W-1:0] f_data;
	logic [4:0] cnt_r, cnt_nxt; // Elements sent
	logic [lws_pkg::TMR_W-1:0] tmr_r, tmr_nxt; // Recovery and precharge wait
	logic [2:0] cmd_nxt;
	logic [lws_pkg::BANK_W-1:0] bank_r, bank_nxt;
	logic [lws_pkg::COL_W-1:0] col_r, col_nxt;
	logic ap_r, ap_nxt;
	logic [lws_pkg::LANES-1:0] stb_nxt;
	logic [lws_pkg::DATA_W-1:0] dq_nxt;
	logic [lws_pkg::LANES-1:0] msk_nxt;
	logic oe_n_nxt;
	// Data path buffer
	lws_fifo #(.WIDTH(W), .DEPTH(lws_pkg::FIFO_DEPTH)) u_fifo (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.in_valid_in(wd_valid_in),
		.in_ready_out(wd_ready_out),
		.in_data_in(wd_data_in),
		.out_valid_out(f_valid),
		.out_ready_in(f_ready),
		.out_data_out(f_data)
	);
	// Write sequencer; starts once one element waits, a dry FIFO stalls the strobe
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
		cmd_nxt = lws_pkg::LWS_CMD_NOP;
		bank_nxt = bank_r;
		col_nxt = col_r;
		ap_nxt = ap_r;
		stb_nxt = '0;
		dq_nxt = link.dq_c;
		msk_nxt = '1;
		oe_n_nxt = 1'b1;
		f_ready = 1'b0;
		case (st_r)
			S_IDLE: begin
				// Writes only: no read burst to stop or wait for
				// One burst at a time; overlap is left to the device
				if (req_valid_in && f_valid && tmr_r == '0) begin
					cmd_nxt = lws_pkg::LWS_CMD_WRITE;
					bank_nxt = req_bank_in;
					col_nxt = req_col_in;
					ap_nxt = req_auto_pre_in;
					oe_n_nxt = 1'b0; // Preamble: strobe driven low
					st_nxt = S_PRE;
				end
			end
			S_PRE: begin
				// First rising edge one clock after the command
				oe_n_nxt = 1'b0;
				stb_nxt = '1;
				f_ready = 1'b1;
				{msk_nxt, dq_nxt} = f_data;
				cnt_nxt = 5'h01;
				st_nxt = S_DATA;
			end
			S_DATA: begin
				oe_n_nxt = 1'b0;
				if (f_valid) begin
					// Each later element on the next strobe edge
					stb_nxt = ~link.strobe_c;
					f_ready = 1'b1;
					{msk_nxt, dq_nxt} = f_data;
					cnt_nxt = cnt_r + 1'b1;
				end else begin
					stb_nxt = link.strobe_c;
					dq_nxt = link.dq_c;
					msk_nxt = link.byte_write_mask;
				end
				if (cnt_r == lws_pkg::BURST_LENGTH) begin
					stb_nxt = '0; // Postamble low
					f_ready = 1'b0;
					st_nxt = S_POST;
				end
			end
			S_POST: begin
				// Wait recovery before any precharge or read
				tmr_nxt = lws_pkg::TMR_W'(lws_pkg::WR_CYC > lws_pkg::WTR_CYC
					? lws_pkg::WR_CYC : lws_pkg::WTR_CYC);
				st_nxt = S_REC;
			end
			S_REC: begin
				if (tmr_r == '0) begin
					// Auto precharge adds row precharge time
					tmr_nxt = ap_r ? lws_pkg::TMR_W'(lws_pkg::RP_CYC) : '0;
					st_nxt = S_IDLE;
				end
			end
			default: begin
				st_nxt = S_IDLE;
			end
		endcase
	end
	// Sequencer registers and link outputs
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			st_r <= S_IDLE;
			cnt_r <= '0;
			tmr_r <= '0;
			bank_r <= '0;
			col_r <= '0;
			ap_r <= 1'b0;
			link.cmd <= lws_pkg::LWS_CMD_NOP;
			link.strobe_c <= '0;
			link.dq_c <= '0;
			link.byte_write_mask <= '1;
			link.dq_c_oe_n <= 1'b1;
			link.strobe_c_oe_n <= 1'b1;
			busy_out <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			tmr_r <= tmr_nxt;
			bank_r <= bank_nxt;
			col_r <= col_nxt;
			ap_r <= ap_nxt;
			link.cmd <= cmd_nxt;
			link.strobe_c <= stb_nxt;
			link.dq_c <= dq_nxt;
			link.byte_write_mask <= msk_nxt;
			link.dq_c_oe_n <= oe_n_nxt;
			link.strobe_c_oe_n <= oe_n_nxt;
			// Busy straight from a flip-flop
			busy_out <= (st_nxt != S_IDLE);
		end
	end
	assign link.bank = bank_r;
	assign link.col = col_r;
	assign link.row = '0;
	assign link.auto_pre = ap_r;
	assign req_ready_out = (st_r == S_IDLE) && f_valid && (tmr_r == '0);
endmodule : lws_ctrl_end

// file: lws_link_monitor.sv
// Purpose: Timing checks on the link between the controller and memory ends
// Assumes: One clock; reset asynchronous, active high
// Notes: Watches the first link only, where both ends are design code
module lws_link_monitor (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// Link signals
	input wire logic [2:0] cmd,
	input wire logic [lws_pkg::LANES-1:0] strobe,
	input wire logic strobe_c_oe_n,
	input wire logic dq_c_oe_n,
	input wire logic dq_d_oe_n,
	input wire logic strobe_d_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// One clock domain, so one default for all
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);
	// Write command on the link
	logic wr;
	assign wr = (cmd == lws_pkg::LWS_CMD_WRITE);
	// Strobe driven low beside the command
	a_preamble_low: assert property (wr |-> (strobe == '0 && !strobe_c_oe_n))
		else $error("strobe not low with write command");
	// First rising edge one clock after the command
	a_first_rise: assert property (wr |=> $rose(strobe[0]))
		else $error("first strobe rise misplaced");
	// One element per strobe level, four in all
	a_strobe_pattern: assert property (wr |=> strobe == '1 ##1 strobe == '0
		##1 strobe == '1 ##1 strobe == '0)
		else $error("strobe pattern wrong in burst");
	// Held low after the last element
	a_postamble_low: assert property (wr |-> ##5 (strobe == '0 && !strobe_c_oe_n))
		else $error("postamble missing");
	// Data driven for every element
	a_data_window: assert property (wr |=> (!dq_c_oe_n) [*4])
		else $error("data released inside burst");
	// Every lane strobe moves together
	a_lanes_agree: assert property (!strobe_c_oe_n |-> (strobe == '0 || strobe == '1))
		else $error("lane strobes disagree");
	// Next write only after postamble and recovery
	a_burst_spacing: assert property (wr |=> (!wr) [*7])
		else $error("write issued before burst complete");
	// Device never drives data or strobe on writes
	a_device_hiz: assert property (dq_d_oe_n && strobe_d_oe_n)
		else $error("device drives link pins");
endmodule : lws_link_monitor

// file: lws_tb_top.sv
// Purpose: Self-checking bench for both ends of the write-burst link
// Assumes: 125 MHz clock; inputs change 1 ns after the rising edge
// Notes: A second link lets the bench drive a memory end directly
module lws_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// Clock, reset and counters
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	int bad_count = 0;
	int n_compared = 0;
	// Controller end user side
	logic req_valid_in = 1'b0;
	logic req_ready_out;
	logic [1:0] req_bank_in = 2'h0;
	logic [8:0] req_col_in = 9'h000;
	logic req_auto_pre_in = 1'b0;
	logic wd_valid_in = 1'b0;
	logic wd_ready_out;
	logic [35:0] wd_data_in = 36'h0;
	logic busy_out;
	// Memory end status, both instances
	logic [3:0] bank_open_out;
	logic [3:0] bank_open2;
	logic [31:0] peek_data_out;
	logic [31:0] peek2_data;
	logic wbusy; // Write busy, first memory end
	logic wbusy2; // Write busy, second memory end
	logic [3:0] peek_addr_in = 4'h0;
	// Bench model of the array and scratch
	logic [31:0] shadow [16];
	logic [31:0] w;
	logic [3:0] a;
	// Rows: {mask per element and lane, auto precharge, bank, column}
	logic [22:0] rows [8] = '{23'h000000, 23'h000014, 23'h000028, 23'h00003C,
		23'h4210C0, 23'h787814, 23'h0703E8, 23'h7FFFBC};
	// Links and ends
	lws_if link ();
	lws_if link2 ();
	lws_ctrl_end lws_ctrl_end_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .link(link),
		.req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_bank_in(req_bank_in),
		.req_col_in(req_col_in), .req_auto_pre_in(req_auto_pre_in), .wd_valid_in(wd_valid_in),
		.wd_ready_out(wd_ready_out), .wd_data_in(wd_data_in), .busy_out(busy_out));
	lws_mem_end lws_mem_end_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .link(link),
		.bank_open_out(bank_open_out), .write_busy_out(wbusy), .peek_data_out(peek_data_out),
		.peek_addr_in(peek_addr_in));
	lws_mem_end lws_mem_end_inst2 (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .link(link2),
		.bank_open_out(bank_open2), .write_busy_out(wbusy2), .peek_data_out(peek2_data),
		.peek_addr_in(peek_addr_in));
	lws_link_monitor lws_link_monitor_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.cmd(link.cmd), .strobe(link.strobe), .strobe_c_oe_n(link.strobe_c_oe_n),
		.dq_c_oe_n(link.dq_c_oe_n), .dq_d_oe_n(link.dq_d_oe_n),
		.strobe_d_oe_n(link.strobe_d_oe_n));
	// Free-running clock
	always #4 clk_sys_in = ~clk_sys_in;
	// Verdict and end of run
	task automatic complete_run();
		if (bad_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h want %h", $time, seen, exp);
		end
	endtask : check
	// Step n edges, land 1 ns after
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : tick
	// Word with distinct lanes
	function automatic logic [31:0] dat(input int i, input int k);
		return 32'h30201000 + 32'h01010101 * (i * 4 + k);
	endfunction : dat
	// Offer one FIFO word, held until taken
	task automatic push(input logic [35:0] d);
		wd_valid_in = 1'b1;
		wd_data_in = d;
		for (int i = 0; i < 100 && wd_ready_out !== 1'b1; i++) begin
			tick(1);
		end
		tick(1);
	endtask : push
	// Request a write, wait for its completion
	task automatic write_req(input logic [1:0] b, input logic [3:0] c, input logic ap);
		req_bank_in = b;
		req_col_in = {5'h00, c};
		req_auto_pre_in = ap;
		req_valid_in = 1'b1;
		for (int i = 0; i < 100 && req_ready_out !== 1'b1; i++) begin
			tick(1);
		end
		tick(1);
		req_valid_in = 1'b0;
		tick(2);
		for (int i = 0; i < 100 && busy_out !== 1'b0; i++) begin
			tick(1);
		end
	endtask : write_req
	// Read back one array word; peek is one cycle late
	task automatic peek(input logic sel, input logic [3:0] ad, input logic [31:0] e);
		peek_addr_in = ad;
		tick(2);
		check(sel ? peek2_data : peek_data_out, e);
	endtask : peek
	// Bench stands in for the controller on the second link
	task automatic beat(input lws_pkg::lws_cmd_e c, input logic [3:0] col, input logic s,
		input logic [31:0] d, input logic [3:0] m);
		link2.cmd = c;
		link2.col = {5'h00, col};
		link2.strobe_c = {4{s}};
		link2.dq_c = d;
		link2.byte_write_mask = m;
		link2.strobe_c_oe_n = 1'b0;
		link2.dq_c_oe_n = 1'b0;
		tick(1);
	endtask : beat
	// Release the second link; the interface pulls it to zero
	task automatic rel2();
		link2.cmd = lws_pkg::LWS_CMD_NOP;
		link2.bank = 2'h0;
		link2.col = 9'h000;
		link2.row = 13'h0000;
		link2.auto_pre = 1'b0;
		link2.strobe_c_oe_n = 1'b1;
		link2.dq_c_oe_n = 1'b1;
		link2.byte_write_mask = 4'hF;
	endtask : rel2
	// One command, one edge, then n more edges
	task automatic cmd2(input lws_pkg::lws_cmd_e c, input logic ap, input int n);
		link2.cmd = c;
		link2.bank = 2'h1;
		link2.auto_pre = ap;
		tick(1);
		link2.cmd = lws_pkg::LWS_CMD_NOP;
		tick(n);
	endtask : cmd2
	// Run takes a few hundred cycles; 12,500 cycles leave wide margin
	initial begin
		#100000;
		bad_count++;
		complete_run();
	end
	// Main sequence
	initial begin
		rel2();
		link2.strobe_c = 4'h0;
		link2.dq_c = 32'h0;
		repeat (20) @(posedge clk_sys_in);
		#1;
		reset_in = 1'b0;
		tick(1);
		check({28'h0, link.byte_write_mask}, 32'hF);
		check({27'h0, busy_out, bank_open_out}, 32'h0);
		// Fill the FIFO with all rows until it refuses
		for (int i = 0; i < 8; i++) begin
			for (int k = 0; k < 4; k++) begin
				push({rows[i][7 + 4 * k +: 4], dat(i, k)});
			end
		end
		wd_valid_in = 1'b0;
		tick(1);
		check({31'h0, wd_ready_out}, 32'h0);
		// Row loop drains the FIFO; bench array merges unmasked lanes
		for (int i = 0; i < 8; i++) begin
			write_req(rows[i][5:4], rows[i][3:0], rows[i][6]);
			for (int k = 0; k < 4; k++) begin
				w = dat(i, k);
				a = rows[i][3:0] + 4'(k);
				for (int j = 0; j < 4; j++) begin
					if (!rows[i][7 + 4 * k + j]) begin
						shadow[a][8 * j +: 8] = w[8 * j +: 8];
					end
				end
				peek(1'b0, a, shadow[a]);
			end
			if (rows[i][6]) begin
				check({31'h0, bank_open_out[rows[i][5:4]]}, 32'h0);
			end
		end
		// Empty FIFO holds requests back
		req_valid_in = 1'b1;
		tick(3);
		check({29'h0, wbusy, req_ready_out, wd_ready_out}, 32'h1);
		req_valid_in = 1'b0;
		// Full burst, then a burst cut after one pair by a new write
		beat(lws_pkg::LWS_CMD_WRITE, 4'h0, 1'b0, 32'h0, 4'hF);
		for (int k = 0; k < 4; k++) begin
			beat(lws_pkg::LWS_CMD_NOP, 4'h0, !k[0], dat(16, k), 4'h0);
		end
		beat(lws_pkg::LWS_CMD_WRITE, 4'h0, 1'b0, 32'h0, 4'hF);
		beat(lws_pkg::LWS_CMD_NOP, 4'h0, 1'b1, dat(17, 0), 4'h0);
		beat(lws_pkg::LWS_CMD_WRITE, 4'h8, 1'b0, dat(17, 1), 4'h0);
		for (int k = 0; k < 4; k++) begin
			beat(lws_pkg::LWS_CMD_NOP, 4'h8, !k[0], dat(18, k), 4'h0);
		end
		beat(lws_pkg::LWS_CMD_NOP, 4'h8, 1'b0, 32'h0, 4'hF);
		rel2();
		tick(4);
		for (int k = 0; k < 4; k++) begin
			peek(1'b1, 4'(k), dat(k < 2 ? 17 : 16, k));
			peek(1'b1, 4'(8 + k), dat(18, k));
		end
		// Activate inside precharge time is ignored
		cmd2(lws_pkg::LWS_CMD_ACTIVE, 1'b0, lws_pkg::RAS_CYC);
		cmd2(lws_pkg::LWS_CMD_PRECHARGE, 1'b0, 0);
		cmd2(lws_pkg::LWS_CMD_ACTIVE, 1'b0, 1);
		check({31'h0, bank_open2[1]}, 32'h0);
		tick(lws_pkg::RP_CYC);
		cmd2(lws_pkg::LWS_CMD_ACTIVE, 1'b0, lws_pkg::RAS_CYC);
		// Burst stop leaves the row open
		cmd2(lws_pkg::LWS_CMD_READ, 1'b0, 0);
		cmd2(lws_pkg::LWS_CMD_BURST_STOP, 1'b0, 2);
		check({31'h0, bank_open2[1]}, 32'h1);
		// Read with auto precharge closes two clocks on, not earlier
		cmd2(lws_pkg::LWS_CMD_READ, 1'b1, 0);
		check({31'h0, bank_open2[1]}, 32'h1);
		tick(1);
		check({31'h0, bank_open2[1]}, 32'h1);
		tick(1);
		check({31'h0, bank_open2[1]}, 32'h0);
		// Write with auto precharge closes the row once recovery ends
		tick(lws_pkg::RP_CYC);
		cmd2(lws_pkg::LWS_CMD_ACTIVE, 1'b1, 0);
		beat(lws_pkg::LWS_CMD_WRITE, 4'h4, 1'b0, 32'h0, 4'hF);
		for (int k = 0; k < 4; k++) begin
			beat(lws_pkg::LWS_CMD_NOP, 4'h4, !k[0], dat(19, k), 4'h0);
		end
		beat(lws_pkg::LWS_CMD_NOP, 4'h4, 1'b0, 32'h0, 4'hF);
		check({30'h0, bank_open2[1], wbusy2}, 32'h3);
		tick(1);
		check({30'h0, bank_open2[1], wbusy2}, 32'h0);
		complete_run();
	end
endmodule : lws_tb_top
